// file: cop_timing_defs.svh
`ifndef COP_TIMING_DEFS_SVH
`define COP_TIMING_DEFS_SVH

// Address offsets relative to the instruction address
`define PC_FETCH_OFS     32'h0000_0008
`define PC_NEXT_OFS      32'h0000_000C
`define VEC_STEP         32'h0000_0004
// Mode encoding entered on the undefined trap
`define MODE_UNDEF       5'h04
// Undefined trap: cycles spent at the fetch address
`define UNDEF_WAIT_CYC   2
// Multiply worst case internal cycles
`define MUL_MAX_I        16
// Reset values
`define PC_RESET         32'h0000_0000
`define VEC_RESET        32'h0000_0004

`endif

// file: cop_timing_pkg.sv
package cop_timing_pkg;

   // Instruction class offered to the pipeline
   typedef enum logic [3:0] {
      CLS_DATA, CLS_STATUS, CLS_LOAD, CLS_STORE, CLS_SWAP, CLS_BRANCH,
      CLS_BLOCK_LOAD, CLS_BLOCK_STORE, CLS_CP_DATA, CLS_CP_LOAD_STORE,
      CLS_CORE_TO_CP, CLS_CP_TO_CORE, CLS_MULTIPLY
   } instr_class_type;

   // Decoded instruction request
   typedef struct packed {
      instr_class_type cls;
      logic            cond_pass;
      logic            reg_shift;
      logic            pc_written;
      logic [4:0]      words;
      logic [4:0]      mul_cycles;
      logic [31:0]     src_data;
      logic [31:0]     data_addr;
   } instr_req_type;

   // Memory side bus outputs
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        mem_request_n;
      logic        sequential_access;
      logic        read_write_n;
      logic        byte_word_n;
      logic        opcode_fetch_n;
      logic        coproc_instr_strobe_n;
      logic        translate_n;
      logic [4:0]  mode;
   } bus_out_type;

endpackage : cop_timing_pkg

// file: cop_timing_core.sv
// Summary of operation
// - A ready store-to-coprocessor takes two cycles, an offer at pc+8 with no memory request then a write at pc+12.
// - While coprocessor busy is high the core waits at pc+8 idle, writing one cycle after it drops.
// - With both lines high the core spends two cycles at pc+8 then fetches vector and vector+4.
// - A condition-failed instruction takes one sequential cycle fetching pc+8.
// - Execution overlaps fetch and decode so cycle counts are incremental.
// - Single instructions take their documented S, N and I counts.
// - Block and coprocessor load/store take their word dependent counts.
// - Coprocessor operations add busy-wait cycles; transfers from the coprocessor to the core also add a coprocessor cycle.
// - Multiply takes 1S plus m internal cycles, at least one and at most sixteen.
`include "cop_timing_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cop_timing_core #(
   parameter logic [31:0] TRAP_VECTOR = `VEC_RESET
) (
   input  wire logic                          CLOCK,
   input  wire logic                          SRST,
   input  wire cop_timing_pkg::instr_req_type REQ,
   input  wire logic                          REQ_VALID,
   output logic                               REQ_READY,
   input  wire logic                          COPROC_ABSENT,
   input  wire logic                          COPROC_BUSY,
   output cop_timing_pkg::bus_out_type        BUS,
   output logic                               TRAP_TAKEN
);

   // ==========================================
   // State
   typedef enum logic [2:0] {
      ST_IDLE, ST_CP_WAIT, ST_SEQ_S, ST_SEQ_N, ST_SEQ_I, ST_CP_C, ST_TRAP
   } state_type;

   state_type                   state_ff,   nxt_state;
   cop_timing_pkg::instr_req_type cur_ff,   nxt_cur;
   cop_timing_pkg::bus_out_type   bus_ff,   nxt_bus;
   logic [31:0]                 pc_ff,      nxt_pc;
   logic [5:0]                  s_cnt_ff,   nxt_s_cnt;
   logic [5:0]                  n_cnt_ff,   nxt_n_cnt;
   logic [5:0]                  i_cnt_ff,   nxt_i_cnt;
   logic [1:0]                  trap_ff,    nxt_trap;
   logic                        c_cyc_ff,   nxt_c_cyc;
   logic                        trap_p_ff,  nxt_trap_p;
   logic                        cdp_done;
   logic [31:0]                 base_pc;
   state_type                   case_state;

   // accepted data op ends in its offer cycle
   assign cdp_done   = (state_ff == ST_CP_WAIT) && (cur_ff.cls == cop_timing_pkg::CLS_CP_DATA)
                       && !COPROC_ABSENT && !COPROC_BUSY;
   assign case_state = cdp_done ? ST_IDLE : state_ff;
   assign base_pc    = pc_ff + (cdp_done ? `VEC_STEP : 32'h0000_0000);
   assign REQ_READY  = (case_state == ST_IDLE);
   assign BUS        = bus_ff;
   assign TRAP_TAKEN = trap_p_ff;

   // ==========================================
   // Next state and bus drive
   always_comb begin
      nxt_state  = case_state;
      nxt_cur    = cur_ff;
      nxt_pc     = base_pc;
      nxt_s_cnt  = s_cnt_ff;
      nxt_n_cnt  = n_cnt_ff;
      nxt_i_cnt  = i_cnt_ff;
      nxt_trap   = trap_ff;
      nxt_c_cyc  = c_cyc_ff;
      nxt_trap_p = 1'b0;
      nxt_bus    = bus_ff;
      // Default: sequential fetch of the next opcode
      nxt_bus.addr                  = base_pc + `PC_FETCH_OFS;
      nxt_bus.mem_request_n         = 1'b0;
      nxt_bus.sequential_access     = 1'b1;
      nxt_bus.read_write_n          = 1'b0;
      nxt_bus.byte_word_n           = 1'b1;
      nxt_bus.opcode_fetch_n        = 1'b0;
      nxt_bus.coproc_instr_strobe_n = 1'b1;
      case (case_state)
         ST_IDLE: begin
            if (REQ_VALID) begin
               nxt_cur = REQ;
               if (!REQ.cond_pass) begin
                  nxt_pc = base_pc + `VEC_STEP;
               end else begin
                  nxt_s_cnt = 6'h00;
                  nxt_n_cnt = 6'h00;
                  nxt_i_cnt = 6'h00;
                  nxt_c_cyc = 1'b0;
                  case (REQ.cls)
                     cop_timing_pkg::CLS_DATA: begin
                        nxt_s_cnt = REQ.pc_written ? 6'h02 : 6'h01;
                        nxt_n_cnt = REQ.pc_written ? 6'h01 : 6'h00;
                        nxt_i_cnt = REQ.reg_shift ? 6'h01 : 6'h00;
                     end
                     cop_timing_pkg::CLS_STATUS: nxt_s_cnt = 6'h01;
                     cop_timing_pkg::CLS_LOAD: begin
                        nxt_s_cnt = REQ.pc_written ? 6'h02 : 6'h01;
                        nxt_n_cnt = REQ.pc_written ? 6'h02 : 6'h01;
                        nxt_i_cnt = 6'h01;
                     end
                     cop_timing_pkg::CLS_STORE: nxt_n_cnt = 6'h02;
                     cop_timing_pkg::CLS_SWAP: begin
                        nxt_s_cnt = 6'h01;
                        nxt_n_cnt = 6'h02;
                        nxt_i_cnt = 6'h01;
                     end
                     cop_timing_pkg::CLS_BRANCH: begin
                        nxt_s_cnt = 6'h02;
                        nxt_n_cnt = 6'h01;
                     end
                     cop_timing_pkg::CLS_BLOCK_LOAD: begin
                        nxt_s_cnt = {1'b0, REQ.words} + (REQ.pc_written ? 6'h01 : 6'h00);
                        nxt_n_cnt = REQ.pc_written ? 6'h02 : 6'h01;
                        nxt_i_cnt = 6'h01;
                     end
                     cop_timing_pkg::CLS_BLOCK_STORE: begin
                        nxt_s_cnt = {1'b0, REQ.words} - 6'h01;
                        nxt_n_cnt = 6'h02;
                     end
                     cop_timing_pkg::CLS_MULTIPLY: begin
                        nxt_s_cnt = 6'h01;
                        nxt_i_cnt = (REQ.mul_cycles > 5'(`MUL_MAX_I)) ? 6'(`MUL_MAX_I)
                                  : (REQ.mul_cycles == 5'h00) ? 6'h01
                                  : {1'b0, REQ.mul_cycles};
                     end
                     default: nxt_s_cnt = 6'h00;
                  endcase
                  // the taking cycle is the first of the count
                  if (nxt_s_cnt != 6'h00) nxt_s_cnt = nxt_s_cnt - 6'h01;
                  else if (nxt_n_cnt != 6'h00) nxt_n_cnt = nxt_n_cnt - 6'h01;
                  else if (nxt_i_cnt != 6'h00) nxt_i_cnt = nxt_i_cnt - 6'h01;
                  if (REQ.cls == cop_timing_pkg::CLS_CP_DATA ||
                      REQ.cls == cop_timing_pkg::CLS_CP_LOAD_STORE ||
                      REQ.cls == cop_timing_pkg::CLS_CORE_TO_CP ||
                      REQ.cls == cop_timing_pkg::CLS_CP_TO_CORE) begin
                     // offer instruction at pc+8 with strobe low, no memory request
                     nxt_bus.addr                  = base_pc + `PC_FETCH_OFS;
                     nxt_bus.coproc_instr_strobe_n = 1'b0;
                     nxt_bus.mem_request_n         = 1'b1;
                     nxt_bus.sequential_access     = 1'b0;
                     nxt_state                     = ST_CP_WAIT;
                     nxt_trap                      = 2'h0;
                  end else if (nxt_s_cnt == 6'h00 && nxt_n_cnt == 6'h00 &&
                               nxt_i_cnt == 6'h00) begin
                     // One-cycle instruction, ready again at once
                     nxt_pc = base_pc + `VEC_STEP;
                  end else begin
                     nxt_bus.mem_request_n = 1'b1;
                     nxt_state = ST_SEQ_I;
                  end
               end
            end
         end
         ST_CP_WAIT: begin
            nxt_bus.addr           = pc_ff + `PC_FETCH_OFS;
            nxt_bus.opcode_fetch_n = 1'b1;
            if (COPROC_ABSENT && COPROC_BUSY) begin
               // two cycles at pc+8 then the trap vector
               nxt_bus.opcode_fetch_n        = 1'b0;
               nxt_bus.coproc_instr_strobe_n = 1'b1;
               nxt_bus.mem_request_n         = 1'b0;
               nxt_bus.sequential_access     = 1'b0;
               nxt_state                     = ST_TRAP;
               nxt_trap                      = 2'h0;
            end else if (COPROC_BUSY) begin
               nxt_bus.mem_request_n         = 1'b1;
               nxt_bus.sequential_access     = 1'b0;
               nxt_bus.coproc_instr_strobe_n = 1'b0;
               nxt_i_cnt                     = i_cnt_ff + 6'h01;
            end else begin
               nxt_bus.coproc_instr_strobe_n = 1'b1;
               nxt_pc                        = pc_ff + `VEC_STEP;
               if (cur_ff.cls == cop_timing_pkg::CLS_CORE_TO_CP) begin
                  nxt_bus.addr              = pc_ff + `PC_NEXT_OFS;
                  nxt_bus.read_write_n      = 1'b1;
                  nxt_bus.wdata             = cur_ff.src_data;
                  nxt_bus.mem_request_n     = 1'b0;
                  nxt_bus.sequential_access = 1'b0;
                  nxt_state                 = ST_IDLE;
               end else if (cur_ff.cls == cop_timing_pkg::CLS_CP_LOAD_STORE) begin
                  nxt_bus.addr              = cur_ff.data_addr;
                  nxt_bus.opcode_fetch_n    = 1'b1;
                  nxt_s_cnt                 = {1'b0, cur_ff.words} - 6'h01;
                  nxt_state                 = (cur_ff.words > 5'h01) ? ST_SEQ_S : ST_IDLE;
               end else if (cur_ff.cls == cop_timing_pkg::CLS_CP_TO_CORE) begin
                  nxt_bus.addr              = pc_ff + `PC_NEXT_OFS;
                  nxt_bus.mem_request_n     = 1'b1;
                  nxt_state                 = ST_CP_C;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_TRAP: begin
            // trap fetches in the undefined mode
            nxt_trap               = trap_ff + 2'h1;
            nxt_bus.translate_n    = 1'b1;
            nxt_bus.mode           = `MODE_UNDEF;
            nxt_bus.addr           = TRAP_VECTOR + {28'h0, trap_ff, 2'h0};
            if (trap_ff == 2'h1) begin
               nxt_trap_p = 1'b1;
               // Handler at the vector runs next, fetching vector+8
               nxt_pc     = TRAP_VECTOR;
               nxt_state  = ST_IDLE;
            end
         end
         ST_SEQ_S: begin
            nxt_bus.addr = bus_ff.addr + `VEC_STEP;
            nxt_bus.opcode_fetch_n = 1'b1;
            // Last word launched when one remains
            nxt_s_cnt = s_cnt_ff - 6'h01;
            if (s_cnt_ff <= 6'h01) nxt_state = ST_IDLE;
         end
         ST_CP_C: begin
            nxt_bus.addr          = pc_ff + `PC_FETCH_OFS;
            nxt_bus.mem_request_n = 1'b0;
            nxt_state             = ST_IDLE;
         end
         ST_SEQ_I, ST_SEQ_N: begin
            // Drain the class count, one cycle each
            nxt_bus.mem_request_n = (i_cnt_ff != 6'h00);
            nxt_bus.sequential_access = (n_cnt_ff == 6'h00);
            if (i_cnt_ff != 6'h00) nxt_i_cnt = i_cnt_ff - 6'h01;
            else if (n_cnt_ff != 6'h00) nxt_n_cnt = n_cnt_ff - 6'h01;
            else if (s_cnt_ff != 6'h00) nxt_s_cnt = s_cnt_ff - 6'h01;
            // Ready again once the last unit is spent
            if (nxt_i_cnt == 6'h00 && nxt_n_cnt == 6'h00 && nxt_s_cnt == 6'h00) begin
               nxt_pc    = pc_ff + `VEC_STEP;
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      if (state_ff != ST_TRAP && nxt_state != ST_TRAP) begin
         nxt_bus.translate_n = bus_ff.translate_n;
         nxt_bus.mode        = bus_ff.mode;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         state_ff  <= ST_IDLE;
         cur_ff    <= '0;
         pc_ff     <= `PC_RESET;
         s_cnt_ff  <= 6'h00;
         n_cnt_ff  <= 6'h00;
         i_cnt_ff  <= 6'h00;
         trap_ff   <= 2'h0;
         c_cyc_ff  <= 1'b0;
         trap_p_ff <= 1'b0;
         bus_ff    <= '{addr: 32'h0000_0000, wdata: 32'h0000_0000, mem_request_n: 1'b1,
                        sequential_access: 1'b0, read_write_n: 1'b0, byte_word_n: 1'b1,
                        opcode_fetch_n: 1'b1, coproc_instr_strobe_n: 1'b1,
                        translate_n: 1'b0, mode: 5'h00};
      end else begin
         state_ff  <= nxt_state;
         cur_ff    <= nxt_cur;
         pc_ff     <= nxt_pc;
         s_cnt_ff  <= nxt_s_cnt;
         n_cnt_ff  <= nxt_n_cnt;
         i_cnt_ff  <= nxt_i_cnt;
         trap_ff   <= nxt_trap;
         c_cyc_ff  <= nxt_c_cyc;
         trap_p_ff <= nxt_trap_p;
         bus_ff    <= nxt_bus;
      end
   end

endmodule : cop_timing_core

`default_nettype wire

// file: cop_timing_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Handshake and bus sequence checker
module cop_timing_monitor #(
   parameter logic [31:0] TRAP_VECTOR = 32'h0000_0004
) (
   input wire logic                          CLOCK,
   input wire logic                          SRST,
   input wire cop_timing_pkg::instr_req_type REQ,
   input wire logic                          REQ_VALID,
   input wire logic                          REQ_READY,
   input wire logic                          COPROC_ABSENT,
   input wire logic                          COPROC_BUSY,
   input wire cop_timing_pkg::bus_out_type   BUS,
   input wire logic                          TRAP_TAKEN
);
   logic stb_n;
   // Short name for the offer strobe
   assign stb_n = BUS.coproc_instr_strobe_n;
   cop_timing_pkg::instr_class_type cls_ff;
   // Class of the instruction last taken
   always_ff @(posedge CLOCK) begin
      if (REQ_VALID && REQ_READY) cls_ff <= REQ.cls;
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);
   ready_write_a: assert property (
      !stb_n && !COPROC_ABSENT && !COPROC_BUSY && cls_ff == cop_timing_pkg::CLS_CORE_TO_CP
      |=> !BUS.mem_request_n && BUS.read_write_n
      && stb_n && BUS.addr == $past(BUS.addr) + 32'h0000_0004) else $error("bad write cycle");
   busy_hold_a: assert property (
      !stb_n && !COPROC_ABSENT && COPROC_BUSY |=> !stb_n && BUS.mem_request_n
      && $stable(BUS.addr)) else $error("busy wait left early");
   offer_read_a: assert property (
      !stb_n |-> !BUS.read_write_n && (!REQ_READY || !COPROC_ABSENT && !COPROC_BUSY))
      else $error("write during offer");
   undef_wait_a: assert property (
      !stb_n && COPROC_ABSENT && COPROC_BUSY |=> !BUS.mem_request_n && stb_n
      && $stable(BUS.addr)) else $error("trap wait cycle wrong");
   trap_fetch_a: assert property (
      !stb_n && COPROC_ABSENT && COPROC_BUSY |=> ##1 BUS.addr == TRAP_VECTOR
      && BUS.mode == 5'h04 && BUS.translate_n && BUS.sequential_access
      ##1 BUS.addr == TRAP_VECTOR + 32'h0000_0004 && BUS.mode == 5'h04)
      else $error("trap fetch wrong");
   trap_pulse_a: assert property (
      !stb_n && COPROC_ABSENT && COPROC_BUSY |-> ##[3:4] TRAP_TAKEN)
      else $error("trap pulse missing");
   cond_skip_a: assert property (
      REQ_VALID && REQ_READY && !REQ.cond_pass |=> !BUS.mem_request_n
      && BUS.sequential_access && stb_n) else $error("skipped cycle wrong");
   reset_idle_a: assert property (
      $past(SRST) |-> BUS.mem_request_n && stb_n && BUS.opcode_fetch_n && REQ_READY)
      else $error("idle after reset wrong");
endmodule : cop_timing_monitor
bind cop_timing_core cop_timing_monitor #(.TRAP_VECTOR(TRAP_VECTOR)) i_mon (.CLOCK(CLOCK),
   .SRST(SRST), .REQ(REQ), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
   .COPROC_ABSENT(COPROC_ABSENT), .COPROC_BUSY(COPROC_BUSY), .BUS(BUS), .TRAP_TAKEN(TRAP_TAKEN));
`default_nettype wire

// file: coproc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Coprocessor watching the offer strobe
module coproc_model (
   input  wire logic       CLOCK,
   input  wire logic       SRST,
   input  wire logic       STROBE_N,
   input  wire logic       REFUSE,
   input  wire logic [3:0] BUSY_CYCLES,
   output logic            ABSENT,
   output logic            BUSY
);
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   // Busy countdown, reloaded while nothing is offered
   always_comb begin
      nxt_cnt = cnt_ff;
      if (SRST || STROBE_N) begin
         nxt_cnt = BUSY_CYCLES;
      end else if (cnt_ff != 4'h0) begin
         nxt_cnt = cnt_ff - 4'h1;
      end
   end
   always_ff @(posedge CLOCK) begin
      cnt_ff <= nxt_cnt;
   end
   // both high when refusing or when the strobe is high
   assign ABSENT = STROBE_N | REFUSE;
   assign BUSY   = STROBE_N | REFUSE | (cnt_ff != 4'h0);
endmodule : coproc_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cop_timing_defs.svh"
// ==========================================
// Bench for the coprocessor timing core
module testbench;
   localparam logic [31:0] VEC = 32'h0000_0100;
   logic                          clock;
   logic                          srst;
   logic                          req_valid;
   logic                          req_ready;
   logic                          absent;
   logic                          busy;
   logic                          refuse;
   logic                          trap_taken;
   logic [3:0]                    busy_cycles;
   cop_timing_pkg::instr_req_type req;
   cop_timing_pkg::bus_out_type   bus;
   int                            mismatches;
   int                            check_count;
   int                            cycles;
   cop_timing_core #(.TRAP_VECTOR(VEC)) i_cop_timing_core (.CLOCK(clock), .SRST(srst),
      .REQ(req), .REQ_VALID(req_valid), .REQ_READY(req_ready), .COPROC_ABSENT(absent),
      .COPROC_BUSY(busy), .BUS(bus), .TRAP_TAKEN(trap_taken));
   coproc_model i_coproc_model (.CLOCK(clock), .SRST(srst), .STROBE_N(bus.coproc_instr_strobe_n),
      .REFUSE(refuse), .BUSY_CYCLES(busy_cycles), .ABSENT(absent), .BUSY(busy));
   // Clock and hang guard
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic step;
      @(posedge clock);
      #10;
   endtask : step
   function automatic cop_timing_pkg::instr_req_type mk(input cop_timing_pkg::instr_class_type c,
      input logic cp, input logic sh, input logic pw, input logic [4:0] w, input logic [4:0] m);
      mk            = '0;
      mk.cls        = c;
      mk.cond_pass  = cp;
      mk.reg_shift  = sh;
      mk.pc_written = pw;
      mk.words      = w;
      mk.mul_cycles = m;
      mk.src_data   = 32'hA5C3_5A3C;
      mk.data_addr  = 32'h0000_0400;
   endfunction : mk
   // Offer one request, return inside its first cycle
   task automatic issue(input cop_timing_pkg::instr_req_type r);
      int n;
      n = 0;
      // One edge between requests, valid never toggles twice at once
      step();
      while (req_ready !== 1'b1 && n < 100) begin
         step();
         n++;
      end
      req       = r;
      req_valid = 1'b1;
      step();
      req_valid = 1'b0;
   endtask : issue
   // Store to coprocessor after b busy cycles
   task automatic t_store(input logic [3:0] b);
      logic [31:0] a;
      int          n;
      busy_cycles = b;
      issue(mk(cop_timing_pkg::CLS_CORE_TO_CP, 1'b1, 1'b0, 1'b0, 5'h01, 5'h00));
      a = bus.addr;
      n = 0;
      while (bus.coproc_instr_strobe_n === 1'b0 && n < 20) begin
         chk("wait mreq_n", 32'h1, {31'h0, bus.mem_request_n});
         chk("wait addr", a, bus.addr);
         step();
         n++;
      end
      chk("offer cycles", 32'(b) + 32'h1, 32'(n));
      chk("write addr", a + 32'h4, bus.addr);
      chk("write rw_n", 32'h1, {31'h0, bus.read_write_n});
      chk("write mreq_n", 32'h0, {31'h0, bus.mem_request_n});
      chk("write data", 32'hA5C3_5A3C, bus.wdata);
      chk("write bw_n", 32'h1, {31'h0, bus.byte_word_n});
      chk("write opc_n", 32'h1, {31'h0, bus.opcode_fetch_n});
      $display("test store busy %0d done", b);
   endtask : t_store
   // Refused offer leads to the trap
   task automatic t_undef;
      logic [31:0] a;
      logic        seen;
      refuse = 1'b1;
      issue(mk(cop_timing_pkg::CLS_CORE_TO_CP, 1'b1, 1'b0, 1'b0, 5'h01, 5'h00));
      a = bus.addr;
      step();
      chk("trap wait addr", a, bus.addr);
      chk("trap wait mreq_n", 32'h0, {31'h0, bus.mem_request_n});
      chk("trap wait opc_n", 32'h0, {31'h0, bus.opcode_fetch_n});
      step();
      chk("vector addr", VEC, bus.addr);
      chk("vector mode", 32'(`MODE_UNDEF), 32'(bus.mode));
      chk("vector trans", 32'h1, {31'h0, bus.translate_n});
      step();
      chk("vector next", VEC + 32'h4, bus.addr);
      seen = trap_taken;
      step();
      chk("trap pulse", 32'h1, {31'h0, seen | trap_taken});
      chk("after trap addr", VEC + 32'h8, bus.addr);
      refuse = 1'b0;
      $display("test undefined done");
   endtask : t_undef
   // Cycles from take until ready again
   task automatic t_count(input cop_timing_pkg::instr_class_type c, input logic cp,
      input logic sh, input logic pw, input logic [4:0] w, input logic [4:0] m, input int exp);
      int n;
      busy_cycles = 4'h0;
      issue(mk(c, cp, sh, pw, w, m));
      if (!cp) begin
         chk("skip seq", 32'h1, {31'h0, bus.sequential_access});
         chk("skip mreq_n", 32'h0, {31'h0, bus.mem_request_n});
      end
      n = 1;
      while (req_ready !== 1'b1 && n < 40) begin
         step();
         n++;
      end
      chk("cycle count", 32'(exp), 32'(n));
      $display("test count class %0d done", c);
   endtask : t_count
   initial begin
      srst        = 1'b1;
      req_valid   = 1'b0;
      refuse      = 1'b0;
      busy_cycles = 4'h0;
      req         = '0;
      mismatches  = 0;
      check_count = 0;
      cycles      = 0;
      repeat (10) step();
      srst = 1'b0;
      t_store(4'h0);
      t_store(4'h3);
      t_undef();
      t_count(cop_timing_pkg::CLS_DATA, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 1);
      t_count(cop_timing_pkg::CLS_DATA, 1'b1, 1'b1, 1'b0, 5'h1, 5'h0, 2);
      t_count(cop_timing_pkg::CLS_DATA, 1'b1, 1'b0, 1'b1, 5'h1, 5'h0, 3);
      t_count(cop_timing_pkg::CLS_STATUS, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 1);
      t_count(cop_timing_pkg::CLS_LOAD, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 3);
      t_count(cop_timing_pkg::CLS_STORE, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 2);
      t_count(cop_timing_pkg::CLS_SWAP, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 4);
      t_count(cop_timing_pkg::CLS_BRANCH, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 3);
      t_count(cop_timing_pkg::CLS_BLOCK_LOAD, 1'b1, 1'b0, 1'b0, 5'h4, 5'h0, 6);
      t_count(cop_timing_pkg::CLS_BLOCK_STORE, 1'b1, 1'b0, 1'b0, 5'h4, 5'h0, 5);
      t_count(cop_timing_pkg::CLS_CP_LOAD_STORE, 1'b1, 1'b0, 1'b0, 5'h2, 5'h0, 3);
      t_count(cop_timing_pkg::CLS_CP_DATA, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 1);
      t_count(cop_timing_pkg::CLS_CP_TO_CORE, 1'b1, 1'b0, 1'b0, 5'h1, 5'h0, 3);
      t_count(cop_timing_pkg::CLS_MULTIPLY, 1'b1, 1'b0, 1'b0, 5'h1, 5'h10, 17);
      t_count(cop_timing_pkg::CLS_SWAP, 1'b0, 1'b0, 1'b0, 5'h1, 5'h0, 1);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
